// ===== src/ddc_params.svh
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

// channel count and register page of each channel
`define DDC_NUM_CHAN       2
`define DDC_PAGE_CHAN0     8'h00
`define DDC_PAGE_CHAN1     8'h01

// register addresses within a page
`define DDC_ADDR_DATA_LOW  8'hd2
`define DDC_ADDR_DATA_HIGH 8'hd3
`define DDC_ADDR_CONTROL   8'hd4

// control register fields
`define DDC_CTL_ENABLE_BIT 7
`define DDC_CTL_MODE_HI    4
`define DDC_CTL_MODE_LO    3
`define DDC_CTL_JUST_HI    2
`define DDC_CTL_JUST_LO    0
`define DDC_CTL_WMASK      8'h9f

// update trigger encodings
`define DDC_MODE_ON_WRITE  2'b00
`define DDC_MODE_TIMER3    2'b01
`define DDC_MODE_TIMER4    2'b10
`define DDC_MODE_TIMER2    2'b11

// justification encodings
`define DDC_JUST_4_8       3'b000
`define DDC_JUST_5_7       3'b001
`define DDC_JUST_6_6       3'b010
`define DDC_JUST_7_5       3'b011
`define DDC_JUST_8_4       3'b1??

// reset values
`define DDC_CTL_RESET      8'h00
`define DDC_DATA_RESET     8'h00
`define DDC_CODE_RESET     12'h000

`endif

// ===== src/ddc_pkg.sv
`include "ddc_params.svh"
package ddc_pkg;

   typedef logic [7:0]  ddc_byte_t;
   typedef logic [11:0] ddc_code_t;
   typedef logic [1:0]  ddc_mode_t;
   typedef logic [2:0]  ddc_just_t;

   // assembles the 12-bit word from the two data bytes
   function automatic ddc_code_t ddc_justify(input ddc_byte_t high,
                                             input ddc_byte_t low,
                                             input ddc_just_t just);
      ddc_code_t code;
      code = `DDC_CODE_RESET;
      casez (just)
         `DDC_JUST_4_8: code = {high[3:0], low};
         `DDC_JUST_5_7: code = {high[4:0], low[7:1]};
         `DDC_JUST_6_6: code = {high[5:0], low[7:2]};
         `DDC_JUST_7_5: code = {high[6:0], low[7:3]};
         `DDC_JUST_8_4: code = {high, low[7:4]};
         default:       code = `DDC_CODE_RESET;
      endcase
      return code;
   endfunction : ddc_justify

endpackage : ddc_pkg

// ===== src/ddc_trigger.sv
`timescale 1ns/10ps
`include "ddc_params.svh"
module ddc_trigger (
   // selected update mode
   input  wire logic            mode_sel,
   input  wire ddc_pkg::ddc_mode_t mode,
   // candidate load events
   input  wire logic            write_high,
   input  wire logic            tmr2_ovf,
   input  wire logic            tmr3_ovf,
   input  wire logic            tmr4_ovf,
   // resulting load strobe
   output logic                 load
);

   always_comb begin
      load = 1'b0;
      case (mode)
         `DDC_MODE_ON_WRITE: load = write_high;
         `DDC_MODE_TIMER3:   load = tmr3_ovf;
         `DDC_MODE_TIMER4:   load = tmr4_ovf;
         `DDC_MODE_TIMER2:   load = tmr2_ovf;
         default:            load = 1'b0;
      endcase
      load = load & mode_sel;
   end

endmodule : ddc_trigger

// ===== src/ddc_format.sv
`timescale 1ns/10ps
`include "ddc_params.svh"
module ddc_format (
   // held data bytes and format select
   input  wire ddc_pkg::ddc_byte_t high,
   input  wire ddc_pkg::ddc_byte_t low,
   input  wire ddc_pkg::ddc_just_t just,
   // assembled converter word
   output ddc_pkg::ddc_code_t      code
);

   assign code = ddc_pkg::ddc_justify(high, low, just);

endmodule : ddc_format

// ===== src/ddc_top.sv
// Notes on behaviour
// - control bit 7 enables the channel; clear means output off and shutdown.
// - control bits 6 and 5 read zero and ignore writes.
// - mode 00 loads the converter latch when the high byte is written.
// - modes 01, 10, 11 load only on timer 3, 4, 2 overflow.
// - format 000 uses high[3:0] above the full low byte.
// - format 001 uses high[4:0] above low[7:1].
// - format 010 uses high[5:0] above low[7:2].
// - format 011 uses high[6:0] above low[7:3].
// - format 1xx uses the full high byte above low[7:4].
// - a second identical channel sits at the same addresses on page 1.
// - reset clears every control bit: disabled, write mode, format 000.
// - in write mode low-byte writes are held; write low before high.
// - in timer modes both bytes are held and copied together on overflow.
`timescale 1ns/10ps
`include "ddc_params.svh"
module ddc_top (
   // clock and reset
   input  wire logic             REF_CLK,
   input  wire logic             RST,
   // special function register access
   input  wire logic [7:0]       SFR_ADDR,
   input  wire logic [7:0]       SFR_PAGE,
   input  wire logic [7:0]       SFR_WDATA,
   input  wire logic             SFR_WR,
   input  wire logic             SFR_RD,
   output logic      [7:0]       SFR_RDATA,
   output logic                  SFR_RVALID,
   output logic                  SFR_HIT,
   // timer overflow strobes
   input  wire logic             TMR2_OVF,
   input  wire logic             TMR3_OVF,
   input  wire logic             TMR4_OVF,
   // channel 0 converter side
   output logic      [11:0]      CHAN0_CODE,
   output logic                  CHAN0_ENABLE,
   output logic                  CHAN0_SHUTDOWN,
   output logic                  CHAN0_UPDATE,
   // channel 1 converter side
   output logic      [11:0]      CHAN1_CODE,
   output logic                  CHAN1_ENABLE,
   output logic                  CHAN1_SHUTDOWN,
   output logic                  CHAN1_UPDATE
);

   localparam int NCH = `DDC_NUM_CHAN;

   // page that selects each channel
   function automatic logic [7:0] chan_page(input int c);
      return (c == 0) ? `DDC_PAGE_CHAN0 : `DDC_PAGE_CHAN1;
   endfunction : chan_page

   // register state
   ddc_pkg::ddc_byte_t data_low      [NCH];
   ddc_pkg::ddc_byte_t data_high     [NCH];
   ddc_pkg::ddc_byte_t control       [NCH];
   ddc_pkg::ddc_byte_t next_data_low [NCH];
   ddc_pkg::ddc_byte_t next_data_high[NCH];
   ddc_pkg::ddc_byte_t next_control  [NCH];

   // converter latch state
   ddc_pkg::ddc_code_t code          [NCH];
   ddc_pkg::ddc_code_t next_code     [NCH];
   logic               update        [NCH];
   logic               next_update   [NCH];

   // read port state
   ddc_pkg::ddc_byte_t rdata;
   ddc_pkg::ddc_byte_t next_rdata;
   logic               rvalid;
   logic               next_rvalid;

   // decode
   logic               page_sel      [NCH];
   logic               wr_low        [NCH];
   logic               wr_high       [NCH];
   logic               wr_ctl        [NCH];
   logic               load          [NCH];
   ddc_pkg::ddc_code_t fmt_code      [NCH];
   logic               addr_known;
   logic               page_known;

   always_comb begin
      addr_known = (SFR_ADDR == `DDC_ADDR_DATA_LOW) ||
                   (SFR_ADDR == `DDC_ADDR_DATA_HIGH) ||
                   (SFR_ADDR == `DDC_ADDR_CONTROL);
      page_known = 1'b0;
      for (int c = 0; c < NCH; c++) begin
         page_sel[c] = (SFR_PAGE == chan_page(c));
         page_known  = page_known | page_sel[c];
         wr_low[c]   = SFR_WR && page_sel[c] && (SFR_ADDR == `DDC_ADDR_DATA_LOW);
         wr_high[c]  = SFR_WR && page_sel[c] && (SFR_ADDR == `DDC_ADDR_DATA_HIGH);
         wr_ctl[c]   = SFR_WR && page_sel[c] && (SFR_ADDR == `DDC_ADDR_CONTROL);
      end
   end

   assign SFR_HIT = (SFR_WR || SFR_RD) && addr_known && page_known;

   // register file: next values
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         next_data_low[c]  = data_low[c];
         next_data_high[c] = data_high[c];
         next_control[c]   = control[c];
         // data bytes are held here until a load copies them
         if (wr_low[c]) begin
            next_data_low[c] = SFR_WDATA;
         end
         if (wr_high[c]) begin
            next_data_high[c] = SFR_WDATA;
         end
         if (wr_ctl[c]) begin
            next_control[c] = SFR_WDATA & `DDC_CTL_WMASK;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      for (int c = 0; c < NCH; c++) begin
         if (RST) begin
            data_low[c]  <= `DDC_DATA_RESET;
            data_high[c] <= `DDC_DATA_RESET;
            control[c]   <= `DDC_CTL_RESET;
         end else begin
            data_low[c]  <= next_data_low[c];
            data_high[c] <= next_data_high[c];
            control[c]   <= next_control[c];
         end
      end
   end

   // per-channel trigger select and formatting
   for (genvar g = 0; g < NCH; g++) begin : g_chan
      ddc_trigger u_trigger (
         .mode_sel   (1'b1),
         .mode       (control[g][`DDC_CTL_MODE_HI:`DDC_CTL_MODE_LO]),
         .write_high (wr_high[g]),
         .tmr2_ovf   (TMR2_OVF),
         .tmr3_ovf   (TMR3_OVF),
         .tmr4_ovf   (TMR4_OVF),
         .load       (load[g])
      );

      // formats the bytes as they stand after this cycle's write
      ddc_format u_format (
         .high (next_data_high[g]),
         .low  (next_data_low[g]),
         .just (control[g][`DDC_CTL_JUST_HI:`DDC_CTL_JUST_LO]),
         .code (fmt_code[g])
      );
   end

   // converter latch: next values
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         next_code[c]   = load[c] ? fmt_code[c] : code[c];
         next_update[c] = load[c];
      end
   end

   always_ff @(posedge REF_CLK) begin
      for (int c = 0; c < NCH; c++) begin
         if (RST) begin
            code[c]   <= `DDC_CODE_RESET;
            update[c] <= 1'b0;
         end else begin
            code[c]   <= next_code[c];
            update[c] <= next_update[c];
         end
      end
   end

   // read port: next values; unmapped reads return zero
   always_comb begin
      next_rdata  = rdata;
      next_rvalid = SFR_RD;
      if (SFR_RD) begin
         next_rdata = `DDC_DATA_RESET;
         for (int c = 0; c < NCH; c++) begin
            if (page_sel[c]) begin
               case (SFR_ADDR)
                  `DDC_ADDR_DATA_LOW:  next_rdata = data_low[c];
                  `DDC_ADDR_DATA_HIGH: next_rdata = data_high[c];
                  `DDC_ADDR_CONTROL:   next_rdata = control[c];
                  default:             next_rdata = `DDC_DATA_RESET;
               endcase
            end
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rdata  <= `DDC_DATA_RESET;
         rvalid <= 1'b0;
      end else begin
         rdata  <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   assign SFR_RDATA  = rdata;
   assign SFR_RVALID = rvalid;

   // converter side outputs
   assign CHAN0_CODE     = code[0];
   assign CHAN1_CODE     = code[1];
   assign CHAN0_ENABLE   = control[0][`DDC_CTL_ENABLE_BIT];
   assign CHAN1_ENABLE   = control[1][`DDC_CTL_ENABLE_BIT];
   assign CHAN0_SHUTDOWN = ~control[0][`DDC_CTL_ENABLE_BIT];
   assign CHAN1_SHUTDOWN = ~control[1][`DDC_CTL_ENABLE_BIT];
   assign CHAN0_UPDATE   = update[0];
   assign CHAN1_UPDATE   = update[1];

endmodule : ddc_top

// ===== dv/ddc_top_assertions.sv
`timescale 1ns/10ps
module ddc_chk (
   // clock and reset
   input wire logic        REF_CLK,
   input wire logic        RST,
   // register access
   input wire logic [7:0]  SFR_ADDR,
   input wire logic [7:0]  SFR_PAGE,
   input wire logic [7:0]  SFR_WDATA,
   input wire logic        SFR_WR,
   input wire logic        SFR_RD,
   input wire logic [7:0]  SFR_RDATA,
   input wire logic        SFR_RVALID,
   input wire logic        SFR_HIT,
   // timers and channel 0
   input wire logic        TMR2_OVF,
   input wire logic        TMR3_OVF,
   input wire logic        TMR4_OVF,
   input wire logic [11:0] CHAN0_CODE,
   input wire logic        CHAN0_ENABLE,
   input wire logic        CHAN0_SHUTDOWN,
   input wire logic        CHAN0_UPDATE
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   logic [1:0] mode;
   logic [1:0] next_mode;
   logic       load;
   logic       acc_ok;
   // shadow of the channel 0 update mode; same-cycle control writes act later
   always_comb begin
      next_mode = RST ? 2'b00 : mode;
      if (!RST && SFR_WR && SFR_PAGE == 8'h00 && SFR_ADDR == 8'hd4) begin
         next_mode = SFR_WDATA[4:3];
      end
      load = (mode == 2'b00 && SFR_WR && SFR_PAGE == 8'h00 && SFR_ADDR == 8'hd3)
          || (mode == 2'b01 && TMR3_OVF) || (mode == 2'b10 && TMR4_OVF)
          || (mode == 2'b11 && TMR2_OVF);
      // mapped access: strobe, page 0 or 1, address d2 to d4
      acc_ok = (SFR_WR || SFR_RD) && SFR_PAGE < 8'h02
            && SFR_ADDR >= 8'hd2 && SFR_ADDR <= 8'hd4;
   end
   always_ff @(posedge REF_CLK) mode <= next_mode;

   rd_answer_a: assert property (SFR_RD |=> SFR_RVALID)
      else $error("read not answered");
   rvalid_cause_a: assert property (SFR_RVALID |-> $past(SFR_RD))
      else $error("read valid without read");
   unused_zero_a: assert property (SFR_RD && SFR_ADDR == 8'hd4 |=> SFR_RDATA[6:5] == 2'b00)
      else $error("unused control bits not zero");
   unmapped_read_a: assert property (SFR_RD && !SFR_HIT |=> SFR_RVALID && SFR_RDATA == 8'h00)
      else $error("unmapped read not zero");
   hit_decode_a: assert property (SFR_HIT == acc_ok)
      else $error("hit does not match address map");
   shutdown_inverse_a: assert property (CHAN0_SHUTDOWN == !CHAN0_ENABLE)
      else $error("shutdown not inverse of enable");
   load_update_a: assert property (load |=> CHAN0_UPDATE)
      else $error("trigger did not update");
   no_load_a: assert property (!load |=> !CHAN0_UPDATE)
      else $error("update without trigger");
   code_hold_a: assert property (!CHAN0_UPDATE && !$past(RST) |-> $stable(CHAN0_CODE))
      else $error("code changed without update");

   cover property (load && (TMR2_OVF || TMR3_OVF || TMR4_OVF));
   cover property (SFR_RD && !SFR_HIT);
   cover property (CHAN0_UPDATE && CHAN0_ENABLE);
endmodule : ddc_chk

// ===== dv/tb.sv
`timescale 1ns/10ps
module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata, lo, hi;
   logic        wr = 1'b0, rd = 1'b0, rvalid, hit, en0, sd0, up0, en1, sd1, up1;
   logic [2:0]  tmr = 3'b000;
   logic [11:0] code0, code1, exp;
   logic [11:0] prev [2] = '{12'h000, 12'h000};
   int          err_total = 0, n_tests = 0, k;

   ddc_top ddc_top_inst (.REF_CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_PAGE(page),
      .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_RVALID(rvalid),
      .SFR_HIT(hit), .TMR2_OVF(tmr[0]), .TMR3_OVF(tmr[1]), .TMR4_OVF(tmr[2]),
      .CHAN0_CODE(code0), .CHAN0_ENABLE(en0), .CHAN0_SHUTDOWN(sd0), .CHAN0_UPDATE(up0),
      .CHAN1_CODE(code1), .CHAN1_ENABLE(en1), .CHAN1_SHUTDOWN(sd1), .CHAN1_UPDATE(up1));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic cmp(string name, logic [11:0] e, logic [11:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", name, e, g);
      end
   endtask : cmp

   task automatic wr_reg(logic [7:0] p, logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      page = p;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg

   task automatic rd_chk(logic [7:0] p, logic [7:0] a, logic [7:0] e);
      @(negedge clk);
      page = p;
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      cmp("rvalid", 12'h001, {11'h000, rvalid});
      cmp("rdata", {4'h0, e}, {4'h0, rdata});
   endtask : rd_chk

   // one-cycle overflow strobes, bit 0 timer 2, bit 1 timer 3, bit 2 timer 4
   task automatic pulse(logic [2:0] t);
      @(negedge clk);
      tmr = t;
      @(negedge clk);
      tmr = 3'b000;
   endtask : pulse

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      finish_test();
   end

   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      cmp("shutdown0", 12'h001, {11'h000, sd0});
      rd_chk(8'h00, 8'hd4, 8'h00);
      rd_chk(8'h01, 8'hd4, 8'h00);
      wr_reg(8'h00, 8'hd4, 8'hff);
      rd_chk(8'h00, 8'hd4, 8'h9f);
      @(negedge clk);
      cmp("enable", 12'h001, {10'h000, en1, en0});
      cmp("shutdown", 12'h002, {10'h000, sd1, sd0});
      for (int p = 0; p < 2; p++) begin
         for (int f = 0; f < 8; f++) begin
            k = (f > 3) ? 4 : f;
            lo = 8'h5a ^ 8'(f * 17);
            hi = 8'hc3 ^ 8'(f * 29);
            exp = 12'({hi, lo} >> k);
            wr_reg(8'(p), 8'hd4, 8'h80 | 8'(f));
            wr_reg(8'(p), 8'hd2, lo);
            cmp("held low", prev[p], p ? code1 : code0);
            wr_reg(8'(p), 8'hd3, hi);
            cmp("code", exp, p ? code1 : code0);
            cmp("update", 12'h001, {11'h000, p ? up1 : up0});
            rd_chk(8'(p), 8'hd2, lo);
            rd_chk(8'(p), 8'hd3, hi);
            prev[p] = exp;
         end
      end
      pulse(3'b111);
      cmp("timer in write mode", prev[0], code0);
      for (int m = 1; m < 4; m++) begin
         k = (m == 3) ? 0 : m;
         wr_reg(8'h00, 8'hd4, 8'(m << 3));
         wr_reg(8'h00, 8'hd2, 8'(m));
         wr_reg(8'h00, 8'hd3, 8'h10 + 8'(m));
         cmp("held both", prev[0], code0);
         pulse(3'b111 ^ (3'b001 << k));
         cmp("other timers", prev[0], code0);
         pulse(3'b001 << k);
         prev[0] = {4'(m), 8'(m)};
         cmp("timer load", prev[0], code0);
      end
      cmp("chan1 kept", prev[1], code1);
      rd_chk(8'h02, 8'hd4, 8'h00);
      rd_chk(8'h00, 8'hd1, 8'h00);
      wr_reg(8'h02, 8'hd4, 8'hff);
      rd_chk(8'h00, 8'hd4, 8'h18);
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd_chk(8'h00, 8'hd4, 8'h00);
      cmp("code after reset", 12'h000, code0);
      finish_test();
   end
endmodule : tb

bind ddc_top ddc_chk ddc_chk_inst (.*);
